// ==== logic/sesb_pkg.sv ====
// Constants and types for the standard event status bank
package sesb_pkg;
  localparam int unsigned SESB_W = 8;
  // Standard event register bit positions
  localparam int unsigned EV_OPC  = 0;
  localparam int unsigned EV_UN1  = 1;
  localparam int unsigned EV_QRY  = 2;
  localparam int unsigned EV_DEV  = 3;
  localparam int unsigned EV_EXE  = 4;
  localparam int unsigned EV_CMD  = 5;
  localparam int unsigned EV_UN6  = 6;
  localparam int unsigned EV_PON  = 7;
  // Status byte bit positions
  localparam int unsigned SB_ESB  = 5;
  localparam int unsigned SB_MSS  = 6;
  localparam logic [7:0] EV_USED_MASK = 8'hbd;
  localparam logic [7:0] SB_SUM_MASK  = 8'hbf;
  // Values after reset
  localparam logic [7:0] RST_EVENTS   = 8'h80;
  localparam logic [7:0] RST_EV_MASK  = 8'h00;
  localparam logic [7:0] RST_SR_MASK  = 8'h00;
  localparam logic [7:0] RST_RESP     = 8'h00;
  typedef enum logic [2:0] {
    SESB_CMD_NONE,
    SESB_CMD_ESE,
    SESB_CMD_ESE_Q,
    SESB_CMD_ESR_Q,
    SESB_CMD_SRE,
    SESB_CMD_SRE_Q,
    SESB_CMD_STB_Q,
    SESB_CMD_CLS
  } sesb_cmd_t;
endpackage

// ==== logic/sesb_sum.sv ====
// Masked summary of an eight-bit flag set
`timescale 1ns/1ps
module sesb_sum
  import sesb_pkg::*;
(
  input  wire logic [7:0] flags_in,  // Flags
  input  wire logic [7:0] mask_in,   // Enable mask
  output logic            any_out    // Any enabled flag set
);
  assign any_out = |(flags_in & mask_in);
endmodule // sesb_sum

// ==== logic/sesb_bank.sv ====
// Standard event status register bank with status byte summaries
// Notes on behaviour
// - Operation-complete bit 0 sets once pending operations finish after the complete command.
// - Event bits 1 and 6 always read as zero.
// - Query error bit 2 sets on empty queue read, early read or full buffers.
// - Device error bit 3 sets on self-test, calibration or device fault.
// - Execution error sets bit 4; command syntax error sets bit 5.
// - Power-on bit 7 sets after reset or power-up until the register is read or cleared.
// - Status byte summary bit reflects any latched standard event whose enable bit is set.
// - Enable-set command stores an eight-bit event enable mask.
// - Enable query returns the current event enable mask.
// - Event query returns the event register value.
// - Clear-status or event query clears the whole event register.
// - Event enable mask clears only through writing zero or reset.
// - Service request mask selects which status byte bits count.
// - Service request mask query returns the stored mask.
// - Status byte query returns the byte without clearing the master bit.
// - Event bits stay latched until read or cleared.
// - Summary at bit 5 counts only enabled event bits.
// - Master bit 6 sets when any enabled summary bit is set.
`timescale 1ns/1ps
module sesb_bank
  import sesb_pkg::*;
(
  input  wire logic       clk_sys_in,        // 100 MHz clock
  input  wire logic       sys_rst_in,        // Sync reset, active high
  input  wire logic [2:0] cmd_in,            // Parsed command code
  input  wire logic       cmd_valid_in,      // Command strobe
  input  wire logic [7:0] cmd_data_in,       // Command argument
  input  wire logic       opc_pending_in,    // Overlapping operations pending
  input  wire logic       qry_err_in,        // Query error event pulse
  input  wire logic       dev_err_in,        // Device error event pulse
  input  wire logic       exe_err_in,        // Execution error event pulse
  input  wire logic       cmd_err_in,        // Command error event pulse
  input  wire logic [7:0] sb_other_in,       // Other status byte summaries
  output logic [7:0]      resp_data_out,     // Query answer
  output logic            resp_valid_out,    // Answer strobe
  output logic [7:0]      status_byte_out,   // Live status byte
  output logic [7:0]      event_flags_out,   // Live event register
  output logic            master_summary_flag_out // Master summary bit
);
  logic [7:0] standard_event_flags;
  logic [7:0] event_enable_mask;
  logic [7:0] service_request_mask;
  logic [7:0] next_ev_mask;
  logic [7:0] next_sr_mask;
  logic       opc_armed;
  logic [7:0] next_events;
  logic [7:0] next_sb_base;
  logic [7:0] next_sb;
  logic       next_esb;
  logic       next_mss;
  logic       ev_clear;
  logic       opc_done;
  sesb_cmd_t  cmd;

  assign cmd = sesb_cmd_t'(cmd_in);
  assign ev_clear = cmd_valid_in && (cmd == SESB_CMD_CLS || cmd == SESB_CMD_ESR_Q);
  assign opc_done = opc_armed && !opc_pending_in;

  // Operation complete arming
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      opc_armed <= 1'b0;
    end else if (cmd_valid_in && cmd == SESB_CMD_NONE && cmd_data_in == 8'h01) begin
      opc_armed <= 1'b1;
    end else if (opc_done) begin
      opc_armed <= 1'b0;
    end
  end

  // Event latch: new events win over clear
  always_comb begin
    next_events = ev_clear ? 8'h00 : standard_event_flags;
    if (opc_done) next_events[EV_OPC] = 1'b1;
    if (qry_err_in) next_events[EV_QRY] = 1'b1;
    if (dev_err_in) next_events[EV_DEV] = 1'b1;
    if (exe_err_in) next_events[EV_EXE] = 1'b1;
    if (cmd_err_in) next_events[EV_CMD] = 1'b1;
    next_events = next_events & EV_USED_MASK;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      standard_event_flags <= RST_EVENTS;
    end else begin
      standard_event_flags <= next_events;
    end
  end

  // Enable masks; summaries use the mask being written so they never lag it
  assign next_ev_mask = (cmd_valid_in && cmd == SESB_CMD_ESE) ? cmd_data_in : event_enable_mask;
  assign next_sr_mask = (cmd_valid_in && cmd == SESB_CMD_SRE) ? cmd_data_in : service_request_mask;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      event_enable_mask    <= RST_EV_MASK;
      service_request_mask <= RST_SR_MASK;
    end else begin
      event_enable_mask    <= next_ev_mask;
      service_request_mask <= next_sr_mask;
    end
  end

  sesb_sum u_esb (
    .flags_in (next_events),
    .mask_in  (next_ev_mask),
    .any_out  (next_esb)
  );

  always_comb begin
    next_sb_base = sb_other_in & SB_SUM_MASK;
    next_sb_base[SB_ESB] = next_esb;
    next_sb_base[7] = 1'b0;
  end

  sesb_sum u_mss (
    .flags_in (next_sb_base),
    .mask_in  (next_sr_mask & SB_SUM_MASK),
    .any_out  (next_mss)
  );

  always_comb begin
    next_sb = next_sb_base;
    next_sb[SB_MSS] = next_mss;
  end

  // Live status outputs
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      status_byte_out         <= 8'h00;
      event_flags_out         <= RST_EVENTS;
      master_summary_flag_out <= 1'b0;
    end else begin
      status_byte_out         <= next_sb;
      event_flags_out         <= next_events;
      master_summary_flag_out <= next_mss;
    end
  end

  // Query answers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      resp_data_out  <= RST_RESP;
      resp_valid_out <= 1'b0;
    end else begin
      resp_valid_out <= 1'b0;
      if (cmd_valid_in) begin
        if (cmd == SESB_CMD_ESE_Q) begin
          resp_data_out  <= event_enable_mask;
          resp_valid_out <= 1'b1;
        end else if (cmd == SESB_CMD_ESR_Q) begin
          resp_data_out  <= standard_event_flags & EV_USED_MASK;
          resp_valid_out <= 1'b1;
        end else if (cmd == SESB_CMD_SRE_Q) begin
          resp_data_out  <= service_request_mask;
          resp_valid_out <= 1'b1;
        end else if (cmd == SESB_CMD_STB_Q) begin
          resp_data_out  <= status_byte_out;
          resp_valid_out <= 1'b1;
        end
      end
    end
  end

  // Checks
  property p_unused_zero;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (event_flags_out[EV_UN1] == 1'b0) && (event_flags_out[EV_UN6] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused event bit set");

  property p_cls_clears;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (cmd_valid_in && cmd == SESB_CMD_CLS && !opc_done && !qry_err_in && !dev_err_in
      && !exe_err_in && !cmd_err_in) |=> (standard_event_flags == 8'h00);
  endproperty
  a_cls_clears: assert property (p_cls_clears) else $error("clear did not empty events");

  property p_latch;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (standard_event_flags[EV_DEV] && !ev_clear) |=> standard_event_flags[EV_DEV];
  endproperty
  a_latch: assert property (p_latch) else $error("event bit dropped");

  property p_dev_set;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    dev_err_in |=> standard_event_flags[EV_DEV];
  endproperty
  a_dev_set: assert property (p_dev_set) else $error("device error lost");

  property p_exe_cmd;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (exe_err_in |=> standard_event_flags[EV_EXE]) and (cmd_err_in |=> standard_event_flags[EV_CMD]);
  endproperty
  a_exe_cmd: assert property (p_exe_cmd) else $error("error flags not set");

  property p_esb;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    status_byte_out[SB_ESB] == |(event_flags_out & event_enable_mask);
  endproperty
  a_esb: assert property (p_esb) else $error("summary bit wrong");

  property p_ese_q;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (cmd_valid_in && cmd == SESB_CMD_ESE_Q) |=> (resp_valid_out && resp_data_out == $past(event_enable_mask));
  endproperty
  a_ese_q: assert property (p_ese_q) else $error("enable query wrong");

  property p_sre_store;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (cmd_valid_in && cmd == SESB_CMD_SRE) ##1 (!cmd_valid_in) [*2] |=>
      (service_request_mask == $past(cmd_data_in, 3));
  endproperty
  a_sre_store: assert property (p_sre_store) else $error("service mask unstable");

  property p_stb_keeps_mss;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (cmd_valid_in && cmd == SESB_CMD_STB_Q && status_byte_out[SB_ESB] && service_request_mask[SB_ESB]) |=>
      (resp_valid_out && resp_data_out[SB_MSS] && master_summary_flag_out);
  endproperty
  a_stb_keeps_mss: assert property (p_stb_keeps_mss) else $error("status read cleared master bit");

  c_esr_read: cover property (@(posedge clk_sys_in) cmd_valid_in && cmd == SESB_CMD_ESR_Q && standard_event_flags != 8'h00);
  c_mss: cover property (@(posedge clk_sys_in) master_summary_flag_out);
  c_opc: cover property (@(posedge clk_sys_in) opc_done);
endmodule // sesb_bank

// ==== sim/sesb_host.sv ====
// Remote host model issuing common commands
`timescale 1ns/1ps
module sesb_host
  import sesb_pkg::*;
(
  input  wire logic  clk_sys_in,    // Clock
  output logic [2:0] cmd_out,       // Command code
  output logic       cmd_valid_out, // Command strobe
  output logic [7:0] cmd_data_out   // Command argument
);
  initial begin
    cmd_out = SESB_CMD_NONE;
    cmd_valid_out = 1'b0;
    cmd_data_out = 8'h00;
  end
  // One command; argument scrambled once released
  task automatic send(input sesb_cmd_t c, input logic [7:0] d);
    @(negedge clk_sys_in);
    cmd_out <= c;
    cmd_data_out <= d;
    cmd_valid_out <= 1'b1;
    @(negedge clk_sys_in);
    cmd_out <= SESB_CMD_NONE;
    cmd_valid_out <= 1'b0;
    cmd_data_out <= ~d;
  endtask
endmodule // sesb_host

// ==== sim/testbench.sv ====
// Self-checking bench for the standard event status bank
`timescale 1ns/1ps
module testbench
  import sesb_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] cmd;
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic opc_pending_in = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] sb_other_in = 8'h00;
  logic [7:0] resp_data_out;
  logic resp_valid_out;
  logic [7:0] status_byte_out;
  logic [7:0] event_flags_out;
  logic master_summary_flag_out;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  sesb_host sesb_host_inst (.clk_sys_in(clk_sys_in), .cmd_out(cmd), .cmd_valid_out(cmd_valid),
    .cmd_data_out(cmd_data));
  sesb_bank sesb_bank_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
    .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data), .opc_pending_in(opc_pending_in),
    .qry_err_in(ev[0]), .dev_err_in(ev[1]), .exe_err_in(ev[2]), .cmd_err_in(ev[3]),
    .sb_other_in(sb_other_in), .resp_data_out(resp_data_out), .resp_valid_out(resp_valid_out),
    .status_byte_out(status_byte_out), .event_flags_out(event_flags_out),
    .master_summary_flag_out(master_summary_flag_out));

  task automatic tally_and_finish;
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Query and compare the answer
  task automatic query(input sesb_cmd_t c, input logic [7:0] exp);
    sesb_host_inst.send(c, 8'h00);
    chk("resp_valid", 8'h01, {7'h0, resp_valid_out});
    chk("resp_data", exp, resp_data_out);
  endtask

  task automatic pulse(input int i);
    @(negedge clk_sys_in);
    ev[i] = 1'b1;
    @(negedge clk_sys_in);
    ev[i] = 1'b0;
  endtask

  initial begin
    logic [7:0] exp;
    wait_n(5);
    sys_rst_in = 1'b0;
    chk("flags", 8'h80, event_flags_out);
    query(SESB_CMD_ESR_Q, 8'h80);
    chk("flags", 8'h00, event_flags_out);
    sesb_host_inst.send(SESB_CMD_ESE, 8'hff);
    query(SESB_CMD_ESE_Q, 8'hff);
    sesb_host_inst.send(SESB_CMD_SRE, 8'h20);
    query(SESB_CMD_SRE_Q, 8'h20);
    exp = 8'h00;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      exp = exp | (8'h04 << i);
      wait_n(1);
      chk("flags", exp, event_flags_out);
    end
    wait_n(2);
    chk("status", 8'h60, status_byte_out);
    query(SESB_CMD_STB_Q, 8'h60);
    chk("master", 8'h01, {7'h0, master_summary_flag_out});
    query(SESB_CMD_ESR_Q, 8'h3c);
    chk("flags", 8'h00, event_flags_out);
    chk("status", 8'h00, status_byte_out);
    opc_pending_in = 1'b1;
    sesb_host_inst.send(SESB_CMD_NONE, 8'h01);
    wait_n(3);
    chk("flags", 8'h00, event_flags_out);
    opc_pending_in = 1'b0;
    wait_n(3);
    chk("flags", 8'h01, event_flags_out);
    sesb_host_inst.send(SESB_CMD_ESE, 8'h00);
    query(SESB_CMD_ESE_Q, 8'h00);
    wait_n(2);
    chk("status", 8'h00, status_byte_out);
    sesb_host_inst.send(SESB_CMD_ESE, 8'h01);
    wait_n(2);
    chk("status", 8'h60, status_byte_out);
    sb_other_in = 8'h04;
    sesb_host_inst.send(SESB_CMD_SRE, 8'h04);
    wait_n(2);
    chk("status", 8'h64, status_byte_out);
    sesb_host_inst.send(SESB_CMD_SRE, 8'h00);
    wait_n(2);
    chk("status", 8'h24, status_byte_out);
    chk("master", 8'h00, {7'h0, master_summary_flag_out});
    sesb_host_inst.send(SESB_CMD_CLS, 8'h00);
    wait_n(2);
    chk("flags", 8'h00, event_flags_out);
    chk("status", 8'h04, status_byte_out);
    query(SESB_CMD_ESE_Q, 8'h01);
    sys_rst_in = 1'b1;
    wait_n(2);
    sys_rst_in = 1'b0;
    chk("flags", 8'h80, event_flags_out);
    query(SESB_CMD_ESR_Q, 8'h80);
    tally_and_finish;
  end
endmodule // testbench
